// ### spm_pkg.sv
// Constants and carrier types for the serial pin mux and port register block.
// Assumes a single system clock and a plain register port on the same clock.
package spm_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CHANNELS = 2;
  localparam int LOW_PINS = 6;

  // Register indices on the plain register port
  localparam logic [3:0] ADDR_PIN_DIRECTION_CTRL = 4'h0;
  localparam logic [3:0] ADDR_OUTPUT_LEVEL_STORE = 4'h1;
  localparam logic [3:0] ADDR_PIN_LEVEL_READBACK = 4'h2;
  localparam logic [3:0] ADDR_LOW_PORT_DIR = 4'h3;
  localparam logic [3:0] ADDR_LOW_PORT_DATA = 4'h4;

  // Reset values, and the value read at unmapped addresses
  localparam logic [7:0] RST_PIN_DIRECTION_CTRL = 8'h00;
  localparam logic [7:0] RST_OUTPUT_LEVEL_STORE = 8'h00;
  localparam logic [5:0] RST_LOW_PORT = 6'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Low port bit positions per channel: clock pin, transmit pin, receive pin
  localparam int POS_CLK0 = 0;
  localparam int POS_TX0 = 1;
  localparam int POS_RX0 = 2;
  localparam int CH_STRIDE = 3;

  // Bus width is 8 bits only when all area width bits are set
  localparam logic [2:0] AREA_ALL_NARROW = 3'h7;

  // Controls and data from one serial channel controller
  typedef struct packed {
    logic rx_on_bit;
    logic tx_on_bit;
    logic clock_select_low;
    logic clock_select_high;
    logic sync_mode;
    logic tx_data;
    logic clk_out;
  } spm_serial_ctrl_s;

  // Operating mode from system control
  typedef struct packed {
    logic external_bus_on;
    logic muxed_bus_on;
    logic [2:0] area_width_sel;
  } spm_mode_s;

endpackage

// ### spm_port_top.sv
// Serial pin mux for the low six pins of the first port and the
// direction, data and pin-read registers of the second port.
// Assumes serial controllers, mode bits and bus controller are on clk_i;
// pin inputs are asynchronous and are synchronised here.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
module spm_port_top
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [spm_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [spm_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [spm_pkg::DATA_W-1:0] reg_rdata_o,
  input wire spm_pkg::spm_mode_s mode_i,
  input wire spm_pkg::spm_serial_ctrl_s [spm_pkg::CHANNELS-1:0] serial_i,
  output logic [spm_pkg::CHANNELS-1:0] serial_rx_o,
  output logic [spm_pkg::CHANNELS-1:0] serial_clk_in_o,
  input wire logic [spm_pkg::LOW_PINS-1:0] low_pin_i,
  output logic [spm_pkg::LOW_PINS-1:0] low_pin_o,
  output logic [spm_pkg::LOW_PINS-1:0] low_pin_oe_o,
  input wire logic [spm_pkg::DATA_W-1:0] bus_data_out_i,
  input wire logic bus_data_oe_i,
  output logic [spm_pkg::DATA_W-1:0] bus_data_in_o,
  input wire logic [spm_pkg::DATA_W-1:0] port_pin_i,
  output logic [spm_pkg::DATA_W-1:0] port_pin_o,
  output logic [spm_pkg::DATA_W-1:0] port_pin_oe_o
);

  ////////////////////////////////////////////////////////////////////////
  // Registers and synchronisers

  logic [7:0] dir_reg;
  logic [7:0] data_reg;
  logic [5:0] low_dir_reg;
  logic [5:0] low_data_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] port_meta_reg;
  logic [7:0] port_sync_reg;
  logic [5:0] low_meta_reg;
  logic [5:0] low_sync_reg;

  wire wr_dir = reg_we_i && (reg_addr_i == spm_pkg::ADDR_PIN_DIRECTION_CTRL);
  wire wr_data = reg_we_i && (reg_addr_i == spm_pkg::ADDR_OUTPUT_LEVEL_STORE);
  wire wr_low_dir = reg_we_i && (reg_addr_i == spm_pkg::ADDR_LOW_PORT_DIR);
  wire wr_low_data = reg_we_i && (reg_addr_i == spm_pkg::ADDR_LOW_PORT_DATA);

  // Pin register has no write decode at all
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      dir_reg <= spm_pkg::RST_PIN_DIRECTION_CTRL;
      data_reg <= spm_pkg::RST_OUTPUT_LEVEL_STORE;
      low_dir_reg <= spm_pkg::RST_LOW_PORT;
      low_data_reg <= spm_pkg::RST_LOW_PORT;
    end
    else
    begin
      if (wr_dir)
        dir_reg <= reg_wdata_i;
      if (wr_data)
        data_reg <= reg_wdata_i;
      if (wr_low_dir)
        low_dir_reg <= reg_wdata_i[5:0];
      if (wr_low_data)
        low_data_reg <= reg_wdata_i[5:0];
    end
  end

  // Pins are asynchronous to clk_i
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      port_meta_reg <= 8'h00;
      port_sync_reg <= 8'h00;
      low_meta_reg <= 6'h00;
      low_sync_reg <= 6'h00;
    end
    else
    begin
      port_meta_reg <= port_pin_i;
      port_sync_reg <= port_meta_reg;
      low_meta_reg <= low_pin_i;
      low_sync_reg <= low_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Second port mode and pin drive

  wire narrow_bus = (mode_i.area_width_sel == spm_pkg::AREA_ALL_NARROW);
  // Multiplexed mode runs the port as in single-chip mode
  wire ext16 = mode_i.external_bus_on && !mode_i.muxed_bus_on && !narrow_bus;

  // Data bus owns the pins in 16-bit mode, direction bits ignored
  assign port_pin_oe_o = ext16 ? {8{bus_data_oe_i}} : dir_reg;
  assign port_pin_o = ext16 ? bus_data_out_i : data_reg;
  assign bus_data_in_o = port_sync_reg;

  // Output bits read back the stored level, inputs the pin
  wire [7:0] pin_read_val = (dir_reg & data_reg) | (~dir_reg & port_sync_reg);

  ////////////////////////////////////////////////////////////////////////
  // Serial pin mux on the low port

  // Clock pin drives when the channel makes its own clock; an outside clock always wins
  function automatic logic clk_pin_drives(input spm_pkg::spm_serial_ctrl_s s);
    clk_pin_drives = !s.clock_select_high && (s.sync_mode || s.clock_select_low);
  endfunction

  genvar ch;
  generate
    for (ch = 0; ch < spm_pkg::CHANNELS; ch = ch + 1)
    begin : g_ch
      localparam int PC = spm_pkg::POS_CLK0 + ch * spm_pkg::CH_STRIDE;
      localparam int PT = spm_pkg::POS_TX0 + ch * spm_pkg::CH_STRIDE;
      localparam int PR = spm_pkg::POS_RX0 + ch * spm_pkg::CH_STRIDE;
      wire clk_is_in = serial_i[ch].clock_select_high;
      wire clk_is_out = clk_pin_drives(serial_i[ch]);

      assign low_pin_oe_o[PR] = !serial_i[ch].rx_on_bit && low_dir_reg[PR];
      assign low_pin_o[PR] = low_data_reg[PR];
      assign serial_rx_o[ch] = low_sync_reg[PR];

      assign low_pin_oe_o[PT] = serial_i[ch].tx_on_bit || low_dir_reg[PT];
      assign low_pin_o[PT] = serial_i[ch].tx_on_bit ? serial_i[ch].tx_data : low_data_reg[PT];

      assign low_pin_oe_o[PC] = clk_is_out || (!clk_is_in && low_dir_reg[PC]);
      assign low_pin_o[PC] = clk_is_out ? serial_i[ch].clk_out : low_data_reg[PC];
      assign serial_clk_in_o[ch] = low_sync_reg[PC];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Read path, answer in the next cycle

  // Direction registers are write-only and read as zero
  always_comb
  begin
    rdata_next = spm_pkg::READ_UNMAPPED;
    case (reg_addr_i)
      spm_pkg::ADDR_OUTPUT_LEVEL_STORE: rdata_next = data_reg;
      spm_pkg::ADDR_PIN_LEVEL_READBACK: rdata_next = pin_read_val;
      spm_pkg::ADDR_LOW_PORT_DATA: rdata_next = {2'b00, low_data_reg};
      default: rdata_next = spm_pkg::READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rdata_reg <= 8'h00;
    else if (reg_re_i)
      rdata_reg <= rdata_next;
    else
      rdata_reg <= 8'h00;
  end

  assign reg_rdata_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  rx_pin_input_a: assert property (serial_i[0].rx_on_bit |-> !low_pin_oe_o[spm_pkg::POS_RX0])
    else $error("receive pin driven while receive on");

  tx_pin_drive_a: assert property (serial_i[1].tx_on_bit |->
    low_pin_oe_o[spm_pkg::POS_TX0 + spm_pkg::CH_STRIDE]
    && low_pin_o[spm_pkg::POS_TX0 + spm_pkg::CH_STRIDE] == serial_i[1].tx_data)
    else $error("transmit pin not carrying serial data");

  clk_pin_in_a: assert property (serial_i[0].clock_select_high |-> !low_pin_oe_o[spm_pkg::POS_CLK0])
    else $error("clock pin driven while external clock");

  clk_pin_out_a: assert property (!serial_i[0].clock_select_high
    && (serial_i[0].sync_mode || serial_i[0].clock_select_low)
    |-> low_pin_oe_o[spm_pkg::POS_CLK0] && low_pin_o[spm_pkg::POS_CLK0] == serial_i[0].clk_out)
    else $error("clock pin not driving serial clock");

  dir_write_a: assert property (wr_dir && !ext16 ##1 !ext16 |->
    port_pin_oe_o == $past(reg_wdata_i))
    else $error("direction write not on pins next cycle");

  data_write_a: assert property (wr_data && !ext16 ##1 !ext16 |->
    ((port_pin_o ^ $past(reg_wdata_i)) & port_pin_oe_o) == 8'h00)
    else $error("data write not on output pins next cycle");

  wide_bus_owns_a: assert property (mode_i.external_bus_on && !mode_i.muxed_bus_on
    && mode_i.area_width_sel != spm_pkg::AREA_ALL_NARROW
    |-> port_pin_oe_o == {8{bus_data_oe_i}} && port_pin_o == bus_data_out_i)
    else $error("direction bits act in 16-bit bus mode");

  narrow_single_a: assert property (mode_i.external_bus_on
    && (mode_i.muxed_bus_on || mode_i.area_width_sel == spm_pkg::AREA_ALL_NARROW)
    |-> port_pin_oe_o == dir_reg && port_pin_o == data_reg)
    else $error("port not in single-chip behaviour");

  pin_read_a: assert property (reg_re_i && reg_addr_i == spm_pkg::ADDR_PIN_LEVEL_READBACK
    |=> reg_rdata_o == (($past(dir_reg) & $past(data_reg)) | (~$past(dir_reg) & $past(port_sync_reg))))
    else $error("pin register read value wrong");

  pin_read_only_a: assert property (reg_we_i && reg_addr_i == spm_pkg::ADDR_PIN_LEVEL_READBACK
    |=> $stable(dir_reg) && $stable(data_reg))
    else $error("write to pin register changed state");

  ////////////////////////////////////////////////////////////////////////
  // Further pin and register checks

  rx_pin_input1_a: assert property (serial_i[1].rx_on_bit
    |-> !low_pin_oe_o[spm_pkg::POS_RX0 + spm_pkg::CH_STRIDE])
    else $error("receive pin one driven while receive on");

  tx_pin_drive0_a: assert property (serial_i[0].tx_on_bit
    |-> low_pin_oe_o[spm_pkg::POS_TX0]
    && low_pin_o[spm_pkg::POS_TX0] == serial_i[0].tx_data)
    else $error("transmit pin zero not carrying serial data");

  clk_pin_in1_a: assert property (serial_i[1].clock_select_high
    |-> !low_pin_oe_o[spm_pkg::POS_CLK0 + spm_pkg::CH_STRIDE])
    else $error("clock pin one driven while external clock");

  clk_pin_out1_a: assert property (!serial_i[1].clock_select_high
    && (serial_i[1].sync_mode || serial_i[1].clock_select_low)
    |-> low_pin_oe_o[spm_pkg::POS_CLK0 + spm_pkg::CH_STRIDE])
    else $error("clock pin one not driving serial clock");

  rx_pin_gpio_a: assert property (!serial_i[0].rx_on_bit
    |-> low_pin_oe_o[spm_pkg::POS_RX0] == low_dir_reg[spm_pkg::POS_RX0])
    else $error("receive pin ignores its direction bit");

  tx_pin_gpio_a: assert property (!serial_i[0].tx_on_bit
    |-> low_pin_oe_o[spm_pkg::POS_TX0] == low_dir_reg[spm_pkg::POS_TX0]
    && low_pin_o[spm_pkg::POS_TX0] == low_data_reg[spm_pkg::POS_TX0])
    else $error("transmit pin ignores its general setting");

  clk_pin_gpio_a: assert property (!serial_i[0].clock_select_high
    && !serial_i[0].sync_mode && !serial_i[0].clock_select_low
    |-> low_pin_oe_o[spm_pkg::POS_CLK0] == low_dir_reg[spm_pkg::POS_CLK0])
    else $error("clock pin ignores its direction bit");

  single_chip_a: assert property (!mode_i.external_bus_on
    |-> port_pin_oe_o == dir_reg && port_pin_o == data_reg)
    else $error("single-chip port not under register control");

  // Read data stand one cycle only, so a stale value cannot be taken twice
  rdata_idle_a: assert property (!reg_re_i
    |=> reg_rdata_o == 8'h00)
    else $error("read data present without a read");

  dir_read_zero_a: assert property (reg_re_i && reg_addr_i == spm_pkg::ADDR_PIN_DIRECTION_CTRL
    |=> reg_rdata_o == spm_pkg::READ_UNMAPPED)
    else $error("write-only direction register read back");

  data_read_a: assert property (reg_re_i && reg_addr_i == spm_pkg::ADDR_OUTPUT_LEVEL_STORE
    |=> reg_rdata_o == $past(data_reg))
    else $error("output data register read wrong");

  low_read_only_a: assert property (reg_we_i && reg_addr_i == spm_pkg::ADDR_PIN_LEVEL_READBACK
    |=> $stable(low_dir_reg) && $stable(low_data_reg))
    else $error("write to pin register changed low port");

  cover_rx_on_c: cover property (serial_i[0].rx_on_bit ##1 !serial_i[0].rx_on_bit);
  cover_wide_bus_c: cover property (ext16 && bus_data_oe_i);
  cover_read_pin_c: cover property (wr_dir ##1 reg_re_i && reg_addr_i == spm_pkg::ADDR_PIN_LEVEL_READBACK);
  cover_clk_out_c: cover property (g_ch[1].clk_is_out);
  cover_tx_on_c: cover property (serial_i[0].tx_on_bit && low_pin_oe_o[spm_pkg::POS_TX0]);

endmodule

// ### spm_pad_model.sv
// Pad partner for the port block: resolves every pad from the block's drive and an outside driver.
// Assumes the bench reshuffles the outside levels, so an undriven pad never keeps a stale value.
`timescale 1ns/10ps
module spm_pad_model
(
  input wire logic [7:0] port_drive_i,
  input wire logic [7:0] port_oe_i,
  input wire logic [7:0] port_outside_i,
  output logic [7:0] port_level_o,
  input wire logic [5:0] low_drive_i,
  input wire logic [5:0] low_oe_i,
  input wire logic [5:0] low_outside_i,
  output logic [5:0] low_level_o
);
  // Block wins where it drives, else the outside source
  assign port_level_o = (port_oe_i & port_drive_i) | (~port_oe_i & port_outside_i);
  assign low_level_o = (low_oe_i & low_drive_i) | (~low_oe_i & low_outside_i);
endmodule

// ### spm_port_top_tb_top.sv
// Self-checking bench for the serial pin mux and port registers.
// Assumes the pad model in its own file and the register port contract of the block.
`timescale 1ns/10ps
module spm_port_top_tb_top;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic [7:0] reg_rdata_o;
  spm_pkg::spm_mode_s mode_i = '0;
  spm_pkg::spm_serial_ctrl_s [1:0] serial_i = '0;
  logic [1:0] serial_rx_o;
  logic [1:0] serial_clk_in_o;
  logic [5:0] low_pin_i;
  logic [5:0] low_pin_o;
  logic [5:0] low_pin_oe_o;
  logic [5:0] low_out = 6'h00;
  logic [7:0] bus_data_out_i = 8'h00;
  logic bus_data_oe_i = 1'b0;
  logic [7:0] bus_data_in_o;
  logic [7:0] port_pin_i;
  logic [7:0] port_pin_o;
  logic [7:0] port_pin_oe_o;
  logic [7:0] port_out = 8'h00;
  logic [7:0] dir;
  logic [7:0] dat;
  logic [7:0] eoe;
  logic [5:0] ldir;
  logic [5:0] ldat;
  logic [5:0] ech;
  logic w16;
  int n_mismatch = 0;
  int check_count = 0;
  int seed = 81;
  always #2 clk_i = ~clk_i;
  spm_port_top spm_port_top_inst (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .mode_i(mode_i), .serial_i(serial_i), .serial_rx_o(serial_rx_o), .serial_clk_in_o(serial_clk_in_o),
    .low_pin_i(low_pin_i), .low_pin_o(low_pin_o), .low_pin_oe_o(low_pin_oe_o), .bus_data_out_i(bus_data_out_i),
    .bus_data_oe_i(bus_data_oe_i), .bus_data_in_o(bus_data_in_o), .port_pin_i(port_pin_i),
    .port_pin_o(port_pin_o), .port_pin_oe_o(port_pin_oe_o));
  spm_pad_model spm_pad_model_inst (.port_drive_i(port_pin_o), .port_oe_i(port_pin_oe_o),
    .port_outside_i(port_out), .port_level_o(port_pin_i), .low_drive_i(low_pin_o), .low_oe_i(low_pin_oe_o),
    .low_outside_i(low_out), .low_level_o(low_pin_i));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("Mismatches %0d of %0d checks", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_we_i <= 1'b1;
    reg_re_i <= 1'b0;
    reg_addr_i <= a;
    reg_wdata_i <= d;
  endtask
  task automatic idle;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
    reg_re_i <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe, so look there
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    reg_re_i <= 1'b1;
    reg_we_i <= 1'b0;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
  endtask
  // Per channel {oe rx,tx,clk ; drive rx,tx,clk}
  function automatic logic [5:0] chan_exp(input spm_pkg::spm_serial_ctrl_s s, input logic [2:0] dr,
    input logic [2:0] dt);
    logic [2:0] oe;
    logic [2:0] o;
    oe = dr;
    o = dt;
    if (s.clock_select_high) oe[0] = 1'b0;
    else if (s.sync_mode | s.clock_select_low) {oe[0], o[0]} = {1'b1, s.clk_out};
    if (s.tx_on_bit) {oe[1], o[1]} = {1'b1, s.tx_data};
    if (s.rx_on_bit) oe[2] = 1'b0;
    return {oe, o & oe};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200000 n_mismatch++;
    test_done();
  end
  initial
  begin
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(spm_pkg::ADDR_OUTPUT_LEVEL_STORE, 8'h00);
    rd(spm_pkg::ADDR_PIN_DIRECTION_CTRL, 8'h00);
    rd(4'hF, spm_pkg::READ_UNMAPPED);
    for (int i = 0; i < 60; i++)
    begin
      @(posedge clk_i);
      // First two passes pin the narrow external and wide external modes
      mode_i <= (i == 0) ? 5'b1_0111 : (i == 1) ? 5'b1_0000 : 5'($random(seed));
      serial_i <= 14'($random(seed));
      low_out <= 6'($random(seed));
      port_out <= 8'($random(seed));
      bus_data_out_i <= 8'($random(seed));
      bus_data_oe_i <= 1'($random(seed));
      dir = 8'($random(seed));
      dat = 8'($random(seed));
      ldir = 6'($random(seed));
      ldat = 6'($random(seed));
      wr(spm_pkg::ADDR_PIN_DIRECTION_CTRL, dir);
      wr(spm_pkg::ADDR_OUTPUT_LEVEL_STORE, dat);
      wr(spm_pkg::ADDR_LOW_PORT_DIR, {2'b00, ldir});
      wr(spm_pkg::ADDR_LOW_PORT_DATA, {2'b00, ldat});
      wr(spm_pkg::ADDR_PIN_LEVEL_READBACK, ~dat);
      idle();
      repeat (2) @(posedge clk_i);
      #1 w16 = mode_i.external_bus_on & ~mode_i.muxed_bus_on & (mode_i.area_width_sel != 3'h7);
      eoe = w16 ? {8{bus_data_oe_i}} : dir;
      chk(port_pin_oe_o, eoe);
      chk(port_pin_o & eoe, (w16 ? bus_data_out_i : dat) & eoe);
      chk(bus_data_in_o, port_pin_i);
      for (int c = 0; c < 2; c++)
      begin
        ech = chan_exp(serial_i[c], ldir[3*c+:3], ldat[3*c+:3]);
        chk({2'b00, low_pin_oe_o[3*c+:3], low_pin_o[3*c+:3] & low_pin_oe_o[3*c+:3]}, {2'b00, ech});
        chk({6'h00, serial_rx_o[c], serial_clk_in_o[c]}, {6'h00, low_pin_i[3*c+2], low_pin_i[3*c]});
      end
      rd(spm_pkg::ADDR_PIN_LEVEL_READBACK, (dir & dat) | (~dir & port_pin_i));
      rd(spm_pkg::ADDR_LOW_PORT_DATA, {2'b00, ldat});
      rd(spm_pkg::ADDR_OUTPUT_LEVEL_STORE, dat);
      rd(spm_pkg::ADDR_PIN_DIRECTION_CTRL, 8'h00);
    end
    @(posedge clk_i);
    mode_i <= 5'b0_0000;
    wr(spm_pkg::ADDR_PIN_DIRECTION_CTRL, 8'hA5);
    #1 chk(port_pin_oe_o, dir);
    idle();
    #1 chk(port_pin_oe_o, 8'hA5);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    @(posedge clk_i);
    resetn_i <= 1'b1;
    #1 chk(port_pin_oe_o, 8'h00);
    rd(spm_pkg::ADDR_OUTPUT_LEVEL_STORE, 8'h00);
    test_done();
  end
endmodule
